// [src/flag_branch_divide_unit.sv]
`timescale 1ns/1ps
`include "flag_branch_params.svh"

module flag_branch_divide_unit (
	input wire logic clk_sys_in,
	input wire logic arst_n_in,
	input wire logic instr_valid_in,
	input wire logic [15:0] instr_half_in,
	input wire logic [31:0] instr_pc_in,
	input wire logic [31:0] src_a_data_in,
	input wire logic [31:0] src_b_data_in,
	input wire logic [31:0] flag_data_in,
	input wire logic hilo_rd_req_in,
	input wire logic hilo_rd_sel_in,
	output logic instr_ready_out,
	output logic [2:0] src_a_sel_out,
	output logic [2:0] src_b_sel_out,
	output logic redirect_out,
	output logic [31:0] redirect_pc_out,
	output flag_branch_pkg::flag_wr_t flag_wr_out,
	output logic div_busy_out,
	output logic hilo_rd_valid_out,
	output logic [31:0] hilo_rd_data_out,
	output logic hilo_stall_out
);

	// ****************************************
	// functions
	// ****************************************
	function automatic logic [31:0] mag32(input logic [31:0] v, input logic sgn);
		return (sgn && v[31]) ? 32'h00000000 - v : v;
	endfunction : mag32

	function automatic flag_branch_pkg::dec_t decode_half(input logic [15:0] h,
			input logic ext, input logic [10:0] pre, input logic [31:0] pc);
		flag_branch_pkg::dec_t d;
		logic [4:0] major;
		d = '0;
		major = h[`MAJOR_HI:`MAJOR_LO];
		d.op = flag_branch_pkg::op_none;
		d.ext = ext;
		d.sel_a = h[`SEL_A_HI:`SEL_A_LO];
		d.sel_b = h[`SEL_B_HI:`SEL_B_LO];
		d.pc = pc;
		d.imm = ext ? {pre[4:0], pre[10:5], h[4:0]} : {8'h00, h[7:0]};
		if (major == `OPC_IMM_GROUP && h[`SEL_A_HI:`SEL_A_LO] == `FN_BR_ZERO) begin
			d.op = flag_branch_pkg::op_brz;
		end else if (major == `OPC_IMM_GROUP && h[`SEL_A_HI:`SEL_A_LO] == `FN_BR_NONZERO) begin
			d.op = flag_branch_pkg::op_brnz;
		end else if (major == `OPC_XOR_COMPARE_IMMEDIATE) begin
			d.op = flag_branch_pkg::op_xor_compare_immediate;
		end else if (!ext && major == `OPC_REG_PAIR) begin
			if (h[`FUNC_HI:`FUNC_LO] == `FN_CMP) begin
				d.op = flag_branch_pkg::op_cmp;
			end else if (h[`FUNC_HI:`FUNC_LO] == `FN_DIV) begin
				d.op = flag_branch_pkg::op_div;
			end else if (h[`FUNC_HI:`FUNC_LO] == `FN_UNSIGNED_QUOTIENT_OP) begin
				d.op = flag_branch_pkg::op_unsigned_quotient_op;
			end
		end
		return d;
	endfunction : decode_half

	// ****************************************
	// declarations
	// ****************************************
	flag_branch_pkg::prefix_state_t ph_ff;
	flag_branch_pkg::div_state_t div_st_ff;
	flag_branch_pkg::dec_t dec_ff;
	flag_branch_pkg::dec_t nxt_dec;
	logic [10:0] pre_ff;
	logic [31:0] pre_pc_ff;
	logic dec_vld_ff;
	logic nxt_dec_vld;
	logic ready_ff;
	logic nxt_ready;
	logic accept;
	logic is_prefix;
	logic dec_is_div;
	logic nxt_is_div;
	logic hold;
	logic ex_fire;
	logic div_start;
	logic flag_zero;
	logic [31:0] br_offset;
	logic [31:0] br_target;
	logic redirect_ff;
	logic [31:0] redirect_pc_ff;
	flag_branch_pkg::flag_wr_t flag_wr_ff;
	logic busy_ff;
	logic [5:0] cnt_ff;
	logic [31:0] rem_ff;
	logic [31:0] quo_ff;
	logic [31:0] dvs_ff;
	logic neg_q_ff;
	logic neg_r_ff;
	logic signed_ff;
	logic [31:0] op_a_ff;
	logic [31:0] op_b_ff;
	logic [32:0] rem_sh;
	logic [32:0] diff;
	logic [31:0] nxt_rem;
	logic [31:0] nxt_quo;
	logic finish;
	logic div_done_ff;
	logic [31:0] quotient_reg_ff;
	logic [31:0] remainder_reg_ff;
	logic rd_pend_ff;
	logic rd_sel_ff;
	logic rd_ack;
	logic rd_valid_ff;
	logic [31:0] rd_data_ff;

	default clocking cb @(posedge clk_sys_in);
	endclocking
	default disable iff (!arst_n_in);

	// ****************************************
	// halfword pairing and decode stage
	// ****************************************
	assign accept = instr_valid_in && ready_ff;
	assign is_prefix = (ph_ff == flag_branch_pkg::ph_idle) &&
		(instr_half_in[`MAJOR_HI:`MAJOR_LO] == `OPC_EXTEND);
	assign dec_is_div = (dec_ff.op == flag_branch_pkg::op_div) ||
		(dec_ff.op == flag_branch_pkg::op_unsigned_quotient_op);
	assign hold = dec_vld_ff && dec_is_div && busy_ff;
	assign ex_fire = dec_vld_ff && !hold;

	always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			ph_ff <= flag_branch_pkg::ph_idle;
			pre_ff <= 11'h000;
			pre_pc_ff <= `RST_WORD;
		end else if (accept) begin
			if (is_prefix) begin
				ph_ff <= flag_branch_pkg::ph_prefix;
				pre_ff <= instr_half_in[10:0];
				pre_pc_ff <= instr_pc_in;
			end else begin
				ph_ff <= flag_branch_pkg::ph_idle;
			end
		end
	end

	always_comb begin
		nxt_dec = dec_ff;
		nxt_dec_vld = 1'b0;
		if (hold) begin
			nxt_dec_vld = 1'b1;
		end else if (accept && !is_prefix) begin
			// the pair reports the prefix address as its own
			nxt_dec = decode_half(instr_half_in, ph_ff == flag_branch_pkg::ph_prefix, pre_ff,
				(ph_ff == flag_branch_pkg::ph_prefix) ? pre_pc_ff : instr_pc_in);
			nxt_dec_vld = (nxt_dec.op != flag_branch_pkg::op_none);
		end
		nxt_is_div = (nxt_dec.op == flag_branch_pkg::op_div) ||
			(nxt_dec.op == flag_branch_pkg::op_unsigned_quotient_op);
		nxt_ready = !(nxt_dec_vld && nxt_is_div && (busy_ff || div_start));
	end

	always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			dec_ff <= '0;
			dec_vld_ff <= 1'b0;
			ready_ff <= 1'b1;
		end else begin
			dec_ff <= nxt_dec;
			dec_vld_ff <= nxt_dec_vld;
			ready_ff <= nxt_ready;
		end
	end

	// ****************************************
	// branch and compare execution
	// ****************************************
	assign flag_zero = (flag_data_in == `RST_WORD);
	assign br_offset = dec_ff.ext ? {{15{dec_ff.imm[15]}}, dec_ff.imm, 1'b0} :
		{{23{dec_ff.imm[7]}}, dec_ff.imm[7:0], 1'b0};
	assign br_target = dec_ff.pc + (dec_ff.ext ? `EXT_NEXT : `SHORT_NEXT) + br_offset;

	always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			redirect_ff <= 1'b0;
			redirect_pc_ff <= `RST_WORD;
		end else begin
			redirect_ff <= ex_fire && (((dec_ff.op == flag_branch_pkg::op_brz) && flag_zero) ||
				((dec_ff.op == flag_branch_pkg::op_brnz) && !flag_zero));
			if (ex_fire) begin
				redirect_pc_ff <= br_target;
			end
		end
	end

	always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			flag_wr_ff <= '0;
		end else begin
			flag_wr_ff.idx <= `FLAG_REG_IDX;
			flag_wr_ff.en <= 1'b0;
			if (ex_fire && dec_ff.op == flag_branch_pkg::op_cmp) begin
				flag_wr_ff.en <= 1'b1;
				flag_wr_ff.data <= src_a_data_in ^ src_b_data_in;
			end else if (ex_fire && dec_ff.op == flag_branch_pkg::op_xor_compare_immediate) begin
				flag_wr_ff.en <= 1'b1;
				flag_wr_ff.data <= src_a_data_in ^ {16'h0000, dec_ff.imm};
			end
		end
	end

	// ****************************************
	// background divider
	// ****************************************
	assign div_start = ex_fire && dec_is_div;
	assign rem_sh = {rem_ff, quo_ff[31]};
	assign diff = rem_sh - {1'b0, dvs_ff};
	assign nxt_rem = diff[32] ? rem_sh[31:0] : diff[31:0];
	assign nxt_quo = {quo_ff[30:0], ~diff[32]};
	assign finish = (div_st_ff == flag_branch_pkg::div_run) && (cnt_ff == `DIV_STEPS - 6'h01);

	always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			div_st_ff <= flag_branch_pkg::div_idle;
			busy_ff <= 1'b0;
			cnt_ff <= 6'h00;
			rem_ff <= `RST_WORD;
			quo_ff <= `RST_WORD;
			dvs_ff <= `RST_WORD;
			neg_q_ff <= 1'b0;
			neg_r_ff <= 1'b0;
			signed_ff <= 1'b0;
			op_a_ff <= `RST_WORD;
			op_b_ff <= `RST_WORD;
		end else begin
			unique case (div_st_ff)
				flag_branch_pkg::div_idle: begin
					if (div_start) begin
						signed_ff <= (dec_ff.op == flag_branch_pkg::op_div);
						op_a_ff <= src_a_data_in;
						op_b_ff <= src_b_data_in;
						quo_ff <= mag32(src_a_data_in, dec_ff.op == flag_branch_pkg::op_div);
						dvs_ff <= mag32(src_b_data_in, dec_ff.op == flag_branch_pkg::op_div);
						neg_q_ff <= (dec_ff.op == flag_branch_pkg::op_div) &&
							(src_a_data_in[31] ^ src_b_data_in[31]);
						neg_r_ff <= (dec_ff.op == flag_branch_pkg::op_div) && src_a_data_in[31];
						rem_ff <= `RST_WORD;
						cnt_ff <= 6'h00;
						busy_ff <= 1'b1;
						div_st_ff <= flag_branch_pkg::div_run;
					end
				end
				flag_branch_pkg::div_run: begin
					// zero divisor just runs its fixed count, no trap path exists
					rem_ff <= nxt_rem;
					quo_ff <= nxt_quo;
					cnt_ff <= cnt_ff + 6'h01;
					if (finish) begin
						busy_ff <= 1'b0;
						div_st_ff <= flag_branch_pkg::div_idle;
					end
				end
			endcase
		end
	end

	always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			quotient_reg_ff <= `RST_WORD;
			remainder_reg_ff <= `RST_WORD;
			div_done_ff <= 1'b0;
		end else begin
			div_done_ff <= finish;
			if (finish) begin
				quotient_reg_ff <= neg_q_ff ? `RST_WORD - nxt_quo : nxt_quo;
				remainder_reg_ff <= neg_r_ff ? `RST_WORD - nxt_rem : nxt_rem;
			end
		end
	end

	// ****************************************
	// quotient and remainder reads
	// ****************************************
	assign rd_ack = (hilo_rd_req_in || rd_pend_ff) && !busy_ff;

	always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			rd_pend_ff <= 1'b0;
			rd_sel_ff <= 1'b0;
			rd_valid_ff <= 1'b0;
			rd_data_ff <= `RST_WORD;
		end else begin
			rd_pend_ff <= (hilo_rd_req_in || rd_pend_ff) && busy_ff;
			if (hilo_rd_req_in && !rd_pend_ff) begin
				rd_sel_ff <= hilo_rd_sel_in;
			end
			rd_valid_ff <= rd_ack;
			if (rd_ack) begin
				rd_data_ff <= (rd_pend_ff ? rd_sel_ff : hilo_rd_sel_in) ?
					remainder_reg_ff : quotient_reg_ff;
			end
		end
	end

	// ****************************************
	// outputs
	// ****************************************
	assign instr_ready_out = ready_ff;
	assign src_a_sel_out = dec_ff.sel_a;
	assign src_b_sel_out = dec_ff.sel_b;
	assign redirect_out = redirect_ff;
	assign redirect_pc_out = redirect_pc_ff;
	assign flag_wr_out = flag_wr_ff;
	assign div_busy_out = busy_ff;
	assign hilo_rd_valid_out = rd_valid_ff;
	assign hilo_rd_data_out = rd_data_ff;
	assign hilo_stall_out = rd_pend_ff;

	// ****************************************
	// checks
	// ****************************************
	sequence div_runs;
		busy_ff [*8] ##24 busy_ff;
	endsequence

	sequence div_ends;
		!busy_ff && div_done_ff;
	endsequence

	zero_branch_taken_a: assert property (ex_fire && dec_ff.op == flag_branch_pkg::op_brz |=>
		redirect_out == $past(flag_zero)) else $error("zero-flag branch decision wrong");
	nonzero_branch_taken_a: assert property (ex_fire && dec_ff.op == flag_branch_pkg::op_brnz |=>
		redirect_out != $past(flag_zero)) else $error("nonzero-flag branch decision wrong");
	branch_target_half_a: assert property (redirect_out |->
		redirect_pc_out - $past(dec_ff.pc, 1) == ($past(dec_ff.ext) ? `EXT_NEXT : `SHORT_NEXT) +
		$past(br_offset)) else $error("branch target wrong");
	target_halfword_align_a: assert property (ex_fire && !dec_ff.pc[0] |=>
		!redirect_pc_out[0]) else $error("target not halfword aligned");
	reg_compare_write_a: assert property (ex_fire && dec_ff.op == flag_branch_pkg::op_cmp |=>
		flag_wr_out.en && flag_wr_out.idx == `FLAG_REG_IDX &&
		flag_wr_out.data == ($past(src_a_data_in) ^ $past(src_b_data_in)))
		else $error("register compare write wrong");
	imm_compare_write_a: assert property (ex_fire && dec_ff.op == flag_branch_pkg::op_xor_compare_immediate |=>
		flag_wr_out.en && flag_wr_out.data[31:16] == $past(src_a_data_in[31:16]))
		else $error("immediate compare not zero-extended");
	divide_no_flag_a: assert property (div_start |=> !flag_wr_out.en)
		else $error("divide wrote a general register");
	divide_completes_a: assert property (div_start |=> div_runs ##1 div_ends)
		else $error("divide did not complete in 33 cycles");
	unsigned_divide_a: assert property (div_done_ff && !signed_ff && op_b_ff != `RST_WORD |->
		{32'h0, quotient_reg_ff} * {32'h0, op_b_ff} + {32'h0, remainder_reg_ff} ==
		{32'h0, op_a_ff}) else $error("unsigned divide result wrong");
	signed_divide_a: assert property (div_done_ff && signed_ff && op_b_ff != `RST_WORD &&
		!(op_a_ff == 32'h80000000 && op_b_ff == 32'hffffffff) |->
		$signed(quotient_reg_ff) * $signed(op_b_ff) + $signed(remainder_reg_ff) ==
		$signed(op_a_ff)) else $error("signed divide result wrong");
	read_stalls_busy_a: assert property (hilo_rd_req_in && busy_ff |=> hilo_stall_out
		##[1:40] hilo_rd_valid_out) else $error("busy read not stalled then answered");
	read_then_divide_a: assert property (hilo_rd_req_in && !busy_ff && !rd_pend_ff |=>
		hilo_rd_valid_out && hilo_rd_data_out == $past(hilo_rd_sel_in ? remainder_reg_ff :
		quotient_reg_ff)) else $error("read beside divide returned wrong value");
	prefix_pair_a: assert property (accept && is_prefix |=> !dec_vld_ff)
		else $error("prefix decoded on its own");

endmodule : flag_branch_divide_unit

// [src/flag_branch_params.svh]
`ifndef FLAG_BRANCH_PARAMS_SVH
`define FLAG_BRANCH_PARAMS_SVH

// ****************************************
// halfword field positions
// ****************************************
`define MAJOR_HI 15
`define MAJOR_LO 11
`define SEL_A_HI 10
`define SEL_A_LO 8
`define SEL_B_HI 7
`define SEL_B_LO 5
`define FUNC_HI 4
`define FUNC_LO 0

// ****************************************
// major opcodes and function codes
// ****************************************
`define OPC_EXTEND 5'h1e
`define OPC_IMM_GROUP 5'h0c
`define OPC_XOR_COMPARE_IMMEDIATE 5'h0e
`define OPC_REG_PAIR 5'h1d
`define FN_BR_ZERO 3'h0
`define FN_BR_NONZERO 3'h1
`define FN_CMP 5'h0a
`define FN_DIV 5'h1a
`define FN_UNSIGNED_QUOTIENT_OP 5'h1b

// ****************************************
// fixed values and counts
// ****************************************
`define FLAG_REG_IDX 5'h18
`define SHORT_NEXT 32'h00000002
`define EXT_NEXT 32'h00000004
`define DIV_STEPS 6'h20
`define RST_WORD 32'h00000000

`endif

// [src/flag_branch_pkg.sv]
package flag_branch_pkg;

	typedef enum logic [1:0] {
		ph_idle = 2'b01,
		ph_prefix = 2'b10
	} prefix_state_t;

	typedef enum logic [1:0] {
		div_idle = 2'b01,
		div_run = 2'b10
	} div_state_t;

	typedef enum logic [6:0] {
		op_none = 7'b0000001,
		op_brz = 7'b0000010,
		op_brnz = 7'b0000100,
		op_cmp = 7'b0001000,
		op_xor_compare_immediate = 7'b0010000,
		op_div = 7'b0100000,
		op_unsigned_quotient_op = 7'b1000000
	} op_t;

	typedef struct packed {
		op_t op;
		logic ext;
		logic [2:0] sel_a;
		logic [2:0] sel_b;
		logic [15:0] imm;
		logic [31:0] pc;
	} dec_t;

	typedef struct packed {
		logic en;
		logic [4:0] idx;
		logic [31:0] data;
	} flag_wr_t;

endpackage : flag_branch_pkg

// [test/regfile_model.sv]
`timescale 1ns/1ps
`include "flag_branch_params.svh"

// ****************************************
// register file and flag register seen by the block
// ****************************************
module regfile_model (
	input wire logic clk_sys_in,
	input wire logic arst_n_in,
	input wire logic [2:0] src_a_sel_in,
	input wire logic [2:0] src_b_sel_in,
	input wire flag_branch_pkg::flag_wr_t flag_wr_in,
	output logic [31:0] src_a_data_out,
	output logic [31:0] src_b_data_out,
	output logic [31:0] flag_data_out
);
	logic [31:0] regs [0:7];
	logic [31:0] flag_ff;
	int n_flag_wr = 0;

	// combinational reads, same cycle as the selectors
	assign src_a_data_out = regs[src_a_sel_in];
	assign src_b_data_out = regs[src_b_sel_in];
	assign flag_data_out = flag_ff;

	// only a write aimed at the flag register lands; any other index is lost
	always @(posedge clk_sys_in) begin
		if (arst_n_in && flag_wr_in.en === 1'b1) begin
			if (flag_wr_in.idx === `FLAG_REG_IDX) begin
				flag_ff <= flag_wr_in.data;
			end
			n_flag_wr <= n_flag_wr + 1;
		end
	end
endmodule : regfile_model

// [test/testbench.sv]
`timescale 1ns/1ps
`include "flag_branch_params.svh"

module testbench;
	logic clk_sys_in, arst_n_in, instr_valid_in, hilo_rd_req_in, hilo_rd_sel_in;
	logic [15:0] instr_half_in;
	logic [31:0] instr_pc_in;
	logic [31:0] src_a_data, src_b_data, flag_data, redirect_pc_out, hilo_rd_data_out;
	logic [2:0] src_a_sel, src_b_sel;
	logic instr_ready_out, redirect_out, div_busy_out, hilo_rd_valid_out, hilo_stall_out;
	flag_branch_pkg::flag_wr_t flag_wr_out;
	int n_errors = 0;
	int tests_run = 0;

	flag_branch_divide_unit dut (.clk_sys_in(clk_sys_in), .arst_n_in(arst_n_in),
		.instr_valid_in(instr_valid_in), .instr_half_in(instr_half_in),
		.instr_pc_in(instr_pc_in), .src_a_data_in(src_a_data), .src_b_data_in(src_b_data),
		.flag_data_in(flag_data), .hilo_rd_req_in(hilo_rd_req_in),
		.hilo_rd_sel_in(hilo_rd_sel_in), .instr_ready_out(instr_ready_out),
		.src_a_sel_out(src_a_sel), .src_b_sel_out(src_b_sel), .redirect_out(redirect_out),
		.redirect_pc_out(redirect_pc_out), .flag_wr_out(flag_wr_out),
		.div_busy_out(div_busy_out), .hilo_rd_valid_out(hilo_rd_valid_out),
		.hilo_rd_data_out(hilo_rd_data_out), .hilo_stall_out(hilo_stall_out));

	regfile_model rf (.clk_sys_in(clk_sys_in), .arst_n_in(arst_n_in),
		.src_a_sel_in(src_a_sel), .src_b_sel_in(src_b_sel), .flag_wr_in(flag_wr_out),
		.src_a_data_out(src_a_data), .src_b_data_out(src_b_data), .flag_data_out(flag_data));

	// ****************************************
	// helpers
	// ****************************************
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			n_errors++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	task automatic wrap_up();
		$display("checks %0d errors %0d", tests_run, n_errors);
		if (n_errors == 0 && tests_run > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask : wrap_up

	task automatic tick(input int n);
		repeat (n) begin
			@(posedge clk_sys_in);
			#1;
		end
	endtask : tick

	// offers one halfword and returns just after the edge that takes it
	task automatic issue(input logic [15:0] half, input logic [31:0] pc);
		instr_half_in = half;
		instr_pc_in = pc;
		instr_valid_in = 1'b1;
		while (instr_ready_out !== 1'b1) tick(1);
		tick(1);
	endtask : issue

	task automatic hrd(input logic sel, output logic [31:0] d, output logic stalled);
		int i;
		stalled = 1'b0;
		hilo_rd_sel_in = sel;
		hilo_rd_req_in = 1'b1;
		tick(1);
		hilo_rd_req_in = 1'b0;
		for (i = 0; i < 40 && hilo_rd_valid_out !== 1'b1; i++) begin
			stalled = stalled | hilo_stall_out;
			tick(1);
		end
		check("read answer", {31'h0, hilo_rd_valid_out}, 32'h1);
		d = hilo_rd_data_out;
	endtask : hrd

	// ****************************************
	// scenarios
	// ****************************************
	task automatic branch(input logic ext, input logic [2:0] fn, input logic [15:0] off,
		input logic [31:0] flag, input logic exp);
		logic [31:0] pc, tgt;
		pc = 32'h00002000;
		rf.flag_ff = flag;
		if (ext) begin
			tgt = pc + `EXT_NEXT + {{15{off[15]}}, off, 1'b0};
			issue({`OPC_EXTEND, off[10:5], off[15:11]}, pc);
			issue({`OPC_IMM_GROUP, fn, 3'h0, off[4:0]}, pc + 32'h2);
		end else begin
			tgt = pc + `SHORT_NEXT + {{23{off[7]}}, off[7:0], 1'b0};
			issue({`OPC_IMM_GROUP, fn, off[7:0]}, pc);
		end
		instr_valid_in = 1'b0;
		tick(1);
		check("redirect", {31'h0, redirect_out}, {31'h0, exp});
		if (exp) check("target", redirect_pc_out, tgt);
	endtask : branch

	task automatic cmpx(input int kind, input logic [31:0] a, input logic [31:0] b);
		logic [31:0] exp;
		rf.regs[3] = a;
		rf.regs[5] = b;
		if (kind == 0) begin
			exp = a ^ b;
			issue({`OPC_REG_PAIR, 3'h3, 3'h5, `FN_CMP}, 32'h1000);
		end else if (kind == 1) begin
			exp = a ^ {24'h0, b[7:0]};
			issue({`OPC_XOR_COMPARE_IMMEDIATE, 3'h3, b[7:0]}, 32'h1000);
		end else begin
			exp = a ^ {16'h0, b[15:0]};
			issue({`OPC_EXTEND, b[10:5], b[15:11]}, 32'h1000);
			issue({`OPC_XOR_COMPARE_IMMEDIATE, 3'h3, 3'h0, b[4:0]}, 32'h1002);
		end
		instr_valid_in = 1'b0;
		tick(1);
		check("flag write", {31'h0, flag_wr_out.en}, 32'h1);
		check("flag index", {27'h0, flag_wr_out.idx}, 32'h18);
		check("flag data", flag_wr_out.data, exp);
		tick(1);
		check("flag reg", rf.flag_ff, exp);
	endtask : cmpx

	task automatic divide(input logic sgn, input logic [31:0] a, input logic [31:0] b,
		input logic [31:0] q, input logic [31:0] r, input logic chk);
		logic [31:0] d;
		logic st;
		int w;
		rf.regs[1] = a;
		rf.regs[2] = b;
		w = rf.n_flag_wr;
		issue({`OPC_REG_PAIR, 3'h1, 3'h2, (sgn ? `FN_DIV : `FN_UNSIGNED_QUOTIENT_OP)}, 32'h3000);
		instr_valid_in = 1'b0;
		tick(3);
		check("busy", {31'h0, div_busy_out}, 32'h1);
		hrd(1'b0, d, st);
		check("stall", {31'h0, st}, 32'h1);
		if (chk) check("quotient", d, q);
		hrd(1'b1, d, st);
		if (chk) check("remainder", d, r);
		else check("idle", {31'h0, div_busy_out}, 32'h0);
		check("flag writes", 32'(rf.n_flag_wr), 32'(w));
	endtask : divide

	task automatic div_pair();
		logic [31:0] d;
		logic st;
		rf.regs[1] = 32'h00000064;
		rf.regs[2] = 32'h00000007;
		// second divide arrives on the edge that starts the first and must wait in decode
		issue({`OPC_REG_PAIR, 3'h1, 3'h2, `FN_UNSIGNED_QUOTIENT_OP}, 32'h3000);
		issue({`OPC_REG_PAIR, 3'h2, 3'h1, `FN_UNSIGNED_QUOTIENT_OP}, 32'h3002);
		instr_valid_in = 1'b0;
		tick(1);
		check("ready while held", {31'h0, instr_ready_out}, 32'h0);
		hrd(1'b0, d, st);
		check("first quotient", d, 32'h0000000e);
		hrd(1'b1, d, st);
		check("held stall", {31'h0, st}, 32'h1);
		check("second remainder", d, 32'h00000007);
		check("ready after", {31'h0, instr_ready_out}, 32'h1);
	endtask : div_pair

	// ****************************************
	// clock, watchdog, main sequence
	// ****************************************
	initial begin
		clk_sys_in = 1'b0;
		forever #10 clk_sys_in = ~clk_sys_in;
	end

	initial begin
		#100000;
		n_errors++;
		wrap_up();
	end

	initial begin
		arst_n_in = 1'b0;
		instr_valid_in = 1'b0;
		instr_half_in = 16'h0000;
		instr_pc_in = 32'h00000000;
		hilo_rd_req_in = 1'b0;
		hilo_rd_sel_in = 1'b0;
		for (int i = 0; i < 8; i++) rf.regs[i] = 32'h00000000;
		rf.flag_ff = 32'h00000000;
		tick(10);
		check("ready in reset", {31'h0, instr_ready_out}, 32'h1);
		check("busy in reset", {31'h0, div_busy_out}, 32'h0);
		arst_n_in = 1'b1;
		tick(1);
		check("index after reset", {27'h0, flag_wr_out.idx}, 32'h18);
		branch(1'b0, `FN_BR_ZERO, 16'h0080, 32'h00000000, 1'b1);
		branch(1'b0, `FN_BR_ZERO, 16'h0080, 32'h00000001, 1'b0);
		branch(1'b0, `FN_BR_NONZERO, 16'h007f, 32'h80000000, 1'b1);
		branch(1'b0, `FN_BR_NONZERO, 16'h007f, 32'h00000000, 1'b0);
		branch(1'b1, `FN_BR_ZERO, 16'h8001, 32'h00000000, 1'b1);
		branch(1'b1, `FN_BR_NONZERO, 16'h7ffe, 32'h00000005, 1'b1);
		branch(1'b1, `FN_BR_NONZERO, 16'h7ffe, 32'h00000000, 1'b0);
		// a prefix broken by a foreign halfword must not extend the next branch
		issue({`OPC_EXTEND, 6'h3f, 5'h1f}, 32'h00001ffc);
		issue(16'h0800, 32'h00001ffe);
		branch(1'b0, `FN_BR_ZERO, 16'h0004, 32'h00000000, 1'b1);
		cmpx(0, 32'h12345678, 32'hffff0000);
		cmpx(1, 32'h12345678, 32'h000000ff);
		cmpx(2, 32'h80000001, 32'h0000beef);
		divide(1'b1, 32'hfffffff9, 32'h00000002, 32'hfffffffd, 32'hffffffff, 1'b1);
		divide(1'b0, 32'hfffffff9, 32'h00000002, 32'h7ffffffc, 32'h00000001, 1'b1);
		divide(1'b1, 32'h00000007, 32'hfffffffe, 32'hfffffffd, 32'h00000001, 1'b1);
		divide(1'b1, 32'h80000000, 32'hffffffff, 32'h80000000, 32'h00000000, 1'b1);
		divide(1'b0, 32'h80000000, 32'hffffffff, 32'h00000000, 32'h80000000, 1'b1);
		divide(1'b0, 32'h00000005, 32'h00000000, 32'h00000000, 32'h00000000, 1'b0);
		divide(1'b1, 32'h00000064, 32'h00000007, 32'h0000000e, 32'h00000002, 1'b1);
		div_pair();
		wrap_up();
	end
endmodule : testbench
